// File: pbt_param_xfer.sv
// parameter block transfer engine of a plug-in analog unit, with apb status port
// Contract
// RQ1: command word 12345 at start: write unit defaults into host block.
// RQ2: command word below 12345 at start: load settings from host into unit.
// RQ3: after default upload, write zero into the command word.
// RQ4: group one refreshed continuously regardless of host operating mode.
// RQ5: group one also refreshed at every power-on and restart.
// RQ6: group two loaded exactly once per start, only if command differs.
// RQ7: range-check both groups; light the settings error lamp on violation.
// RQ8: write offset of first offending word into display word.
// RQ9: group one violation shown and stored immediately.
// RQ10: group two violation shown and stored only at power-on or restart.
// RQ11: host restarts unit after block change via power or restart bit.
// RQ12: host writes 12345 to command word then restarts to get defaults.
// RQ13: block is 100 words at 20000 plus 100 times unit number.
// RQ14: rising restart bit reruns the whole power-on transfer sequence.
`timescale 1ns/1ps
module pbt_param_xfer (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [6:0]            unit_sw,
    input  wire logic                  restart_bit,
    output pbt_pkg::pbt_mem_req_t      mem_req,
    input  wire pbt_pkg::pbt_mem_rsp_t mem_rsp,
    output logic                       settings_error_lamp,
    output logic                       irq
);
    // =====================================================================
    // state
    // =====================================================================
    pbt_pkg::pbt_state_t   st_r, st_nxt;
    pbt_pkg::pbt_mem_req_t mem_req_r;
    logic [6:0]            idx_r, idx_nxt;
    logic [7:0]            sync1_r, sync2_r;
    logic                  rst_q_r;
    logic                  restart_pend_r;
    logic [14:0]           base_r;
    logic [6:0]            unit_r;
    logic                  g1_err_r, g2_err_r, pass_bad_r;
    logic [6:0]            g1_off_r, g2_off_r;
    logic [15:0]           shown_off_r;
    logic                  shown_vld_r;
    logic [15:0]           cfg_mem [pbt_pkg::BLK_WORDS];
    logic [pbt_pkg::EV_W-1:0] status_r, mask_r;
    logic [6:0]            cfg_sel_r;
    logic [31:0]           prdata_r;
    logic                  pready_r, pslverr_r, irq_r, lamp_r;
    logic                  chk_ok;
    logic [15:0]           chk_def;

    // =====================================================================
    // pin synchronisers and restart detection
    // =====================================================================
    // synchroniser runs through reset so the unit number is settled at the first start
    always_ff @(posedge pclk) begin
        sync1_r <= {restart_bit, unit_sw};
        sync2_r <= sync1_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rst_q_r <= 1'b0;
        else          rst_q_r <= sync2_r[7];
    end

    wire        take        = mem_req_r.req & mem_rsp.ack;
    wire        restart_rise = sync2_r[7] & ~rst_q_r;  // [RQ14]
    wire        apb_setup   = psel & ~penable;
    wire        apb_acc     = psel & penable & pready_r;
    wire        apb_wr      = apb_acc & pwrite;
    wire        ctrl_restart = apb_wr & (paddr == pbt_pkg::ADR_CTRL)
                               & pwdata[pbt_pkg::CTRL_RESTART];
    wire        restart_go  = restart_pend_r & (~mem_req_r.req | mem_rsp.ack);
    wire        start       = restart_go | (st_r == pbt_pkg::ST_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) restart_pend_r <= 1'b0;
        else          restart_pend_r <= restart_rise | ctrl_restart
                                        | (restart_pend_r & ~restart_go);  // [RQ14]
    end

    // =====================================================================
    // block addressing and access selection
    // =====================================================================
    wire        is_g1_rd = (st_r == pbt_pkg::ST_LOAD1) || (st_r == pbt_pkg::ST_REFR);
    wire        is_g2_rd = (st_r == pbt_pkg::ST_LOAD2);
    wire        last_g1  = (idx_r == pbt_pkg::OFF_G1_LAST);
    wire        last_g2  = (idx_r == pbt_pkg::OFF_G2_LAST);
    wire        bad      = take & (is_g1_rd | is_g2_rd) & ~chk_ok;  // [RQ7]
    wire        first_bad = bad & ~pass_bad_r;
    wire [15:0] disp_off = g1_err_r ? {9'h000, g1_off_r} : {9'h000, g2_off_r};
    wire        disp_due = (g1_err_r | g2_err_r)
                           & (~shown_vld_r | (shown_off_r != disp_off));
    wire        to_errw  = (st_r == pbt_pkg::ST_REFR) & ~mem_req_r.req & disp_due;
    wire        is_cmd_word = (st_r == pbt_pkg::ST_CMD) || (st_r == pbt_pkg::ST_CLR);
    wire [6:0]  acc_off  = is_cmd_word ? pbt_pkg::OFF_CMD :
                           (st_r == pbt_pkg::ST_ERRW) ? pbt_pkg::OFF_DISP : idx_r;
    wire        acc_we   = (st_r == pbt_pkg::ST_UPLD) || (st_r == pbt_pkg::ST_CLR)
                           || (st_r == pbt_pkg::ST_ERRW);
    wire [15:0] acc_data = (st_r == pbt_pkg::ST_UPLD) ? chk_def :
                           (st_r == pbt_pkg::ST_ERRW) ? disp_off : pbt_pkg::CMD_CLEARED;
    wire        issue    = ~mem_req_r.req & ~start & ~to_errw;
    wire [14:0] unit_base = 15'(pbt_pkg::BASE_WORD + {8'h00, sync2_r[6:0]}
                                * pbt_pkg::UNIT_STRIDE);  // [RQ13]

    pbt_range_chk u_chk (
        .offset    (idx_r),
        .value     (mem_rsp.rdata),
        .in_range  (chk_ok),
        .def_value (chk_def)
    );

    // =====================================================================
    // transfer sequencer
    // =====================================================================
    always_comb begin
        st_nxt  = st_r;
        idx_nxt = idx_r;
        if (start) begin
            st_nxt  = pbt_pkg::ST_CMD;  // [RQ5] [RQ14]
            idx_nxt = pbt_pkg::OFF_G1_FIRST;
        end else if (to_errw) begin
            st_nxt = pbt_pkg::ST_ERRW;  // [RQ9]
        end else if (take) begin
            case (st_r)
                pbt_pkg::ST_CMD: begin
                    if (mem_rsp.rdata == pbt_pkg::CMD_UPLOAD) st_nxt = pbt_pkg::ST_UPLD;  // [RQ1]
                    else                                      st_nxt = pbt_pkg::ST_LOAD1; // [RQ2]
                end
                pbt_pkg::ST_UPLD: begin
                    if (last_g2) st_nxt = pbt_pkg::ST_CLR;  // [RQ3]
                    else         idx_nxt = 7'(idx_r + 7'h01);
                end
                pbt_pkg::ST_CLR: begin
                    st_nxt  = pbt_pkg::ST_REFR;
                    idx_nxt = pbt_pkg::OFF_G1_FIRST;
                end
                pbt_pkg::ST_LOAD1: begin
                    if (last_g1) begin
                        st_nxt  = pbt_pkg::ST_LOAD2;  // [RQ6]
                        idx_nxt = pbt_pkg::OFF_G2_FIRST;
                    end else begin
                        idx_nxt = 7'(idx_r + 7'h01);
                    end
                end
                pbt_pkg::ST_LOAD2: begin
                    if (last_g2) begin
                        st_nxt  = pbt_pkg::ST_REFR;
                        idx_nxt = pbt_pkg::OFF_G1_FIRST;
                    end else begin
                        idx_nxt = 7'(idx_r + 7'h01);
                    end
                end
                pbt_pkg::ST_REFR: begin
                    idx_nxt = last_g1 ? pbt_pkg::OFF_G1_FIRST : 7'(idx_r + 7'h01);  // [RQ4]
                end
                pbt_pkg::ST_ERRW: st_nxt = pbt_pkg::ST_REFR;
                default:          st_nxt = pbt_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= pbt_pkg::ST_IDLE;
            idx_r  <= pbt_pkg::OFF_G1_FIRST;
            base_r <= pbt_pkg::BASE_WORD;
            unit_r <= 7'h00;
        end else begin
            st_r  <= st_nxt;
            idx_r <= idx_nxt;
            if (start) begin
                base_r <= unit_base;
                unit_r <= sync2_r[6:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req_r <= '0;
        end else if (start || take) begin
            mem_req_r.req <= 1'b0;
        end else if (issue) begin
            mem_req_r.req   <= 1'b1;
            mem_req_r.we    <= acc_we;
            mem_req_r.addr  <= 15'(base_r + {8'h00, acc_off});
            mem_req_r.wdata <= acc_data;
        end
    end

    // =====================================================================
    // local settings copy
    // =====================================================================
    always_ff @(posedge pclk) begin
        if (take && (is_g1_rd || is_g2_rd) && chk_ok) cfg_mem[idx_r] <= mem_rsp.rdata;
        else if (take && st_r == pbt_pkg::ST_UPLD)    cfg_mem[idx_r] <= chk_def;
    end

    // =====================================================================
    // range error tracking
    // =====================================================================
    wire g1_pass_end = take & is_g1_rd & last_g1;
    wire g2_pass_end = take & is_g2_rd & last_g2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g1_err_r    <= 1'b0;
            g2_err_r    <= 1'b0;
            pass_bad_r  <= 1'b0;
            g1_off_r    <= 7'h00;
            g2_off_r    <= 7'h00;
            shown_off_r <= 16'h0000;
            shown_vld_r <= 1'b0;
        end else if (start) begin
            g1_err_r    <= 1'b0;
            g2_err_r    <= 1'b0;
            pass_bad_r  <= 1'b0;
            shown_vld_r <= 1'b0;
        end else begin
            if (first_bad && is_g1_rd) begin
                g1_err_r <= 1'b1;  // [RQ9]
                g1_off_r <= idx_r;
            end else if (g1_pass_end && !pass_bad_r) begin
                g1_err_r <= 1'b0;
            end
            if (first_bad && is_g2_rd) begin
                g2_err_r <= 1'b1;  // [RQ10]
                g2_off_r <= idx_r;
            end
            if (g1_pass_end || g2_pass_end) pass_bad_r <= 1'b0;
            else if (bad)                   pass_bad_r <= 1'b1;
            if (take && st_r == pbt_pkg::ST_ERRW) begin
                shown_off_r <= mem_req_r.wdata;  // [RQ8]
                shown_vld_r <= 1'b1;
            end
        end
    end

    // =====================================================================
    // apb slave, events and interrupt
    // =====================================================================
    wire sel_status = (paddr == pbt_pkg::ADR_STATUS);
    wire mapped     = (paddr == pbt_pkg::ADR_CTRL) || sel_status
                      || (paddr == pbt_pkg::ADR_MASK) || (paddr == pbt_pkg::ADR_STATE)
                      || (paddr == pbt_pkg::ADR_CFG_SEL) || (paddr == pbt_pkg::ADR_CFG_DATA);
    wire [31:0] rd_mux =
        sel_status ? {28'h0000000, status_r} :
        (paddr == pbt_pkg::ADR_MASK)     ? {28'h0000000, mask_r} :
        (paddr == pbt_pkg::ADR_STATE)    ? {2'h0, unit_r, st_r, (st_r != pbt_pkg::ST_REFR),
                                            g2_err_r, g1_err_r, lamp_r, shown_off_r} :
        (paddr == pbt_pkg::ADR_CFG_SEL)  ? {25'h0000000, cfg_sel_r} :
        (paddr == pbt_pkg::ADR_CFG_DATA) ? {16'h0000, cfg_mem[cfg_sel_r]} : 32'h00000000;
    wire [pbt_pkg::EV_W-1:0] ev_set = {restart_go, first_bad, g2_pass_end,
                                       take & (st_r == pbt_pkg::ST_CLR)};
    wire [pbt_pkg::EV_W-1:0] rd_clr = (apb_acc & ~pwrite & sel_status)
                                      ? prdata_r[pbt_pkg::EV_W-1:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup & ~mapped;
            if (apb_setup && !pwrite) prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r  <= pbt_pkg::STATUS_RST;
            mask_r    <= pbt_pkg::MASK_RST;
            cfg_sel_r <= 7'h00;
            irq_r     <= 1'b0;
            lamp_r    <= 1'b0;
        end else begin
            status_r <= (status_r & ~rd_clr) | ev_set;
            if (apb_wr && paddr == pbt_pkg::ADR_MASK)    mask_r <= pwdata[pbt_pkg::EV_W-1:0];
            if (apb_wr && paddr == pbt_pkg::ADR_CFG_SEL) cfg_sel_r <= pwdata[6:0];
            irq_r  <= |(status_r & mask_r);
            lamp_r <= g1_err_r | g2_err_r;  // [RQ7]
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign mem_req             = mem_req_r;
    assign settings_error_lamp = lamp_r;
    assign irq                 = irq_r;

    // =====================================================================
    // assertions
    // =====================================================================
    AST_UPLOAD_DIR: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ1]
        (take && st_r == pbt_pkg::ST_CMD && mem_rsp.rdata == pbt_pkg::CMD_UPLOAD && !start)
        |=> st_r == pbt_pkg::ST_UPLD ##1 (mem_req_r.req && mem_req_r.we) or restart_pend_r)
        else $error("upload not started after command 12345");
    AST_LOAD_DIR: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ2]
        (take && st_r == pbt_pkg::ST_CMD && mem_rsp.rdata != pbt_pkg::CMD_UPLOAD && !start)
        |=> st_r == pbt_pkg::ST_LOAD1)
        else $error("normal load not started");
    AST_CLR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ3]
        (mem_req_r.req && st_r == pbt_pkg::ST_CLR)
        |-> mem_req_r.we && mem_req_r.wdata == 16'h0000 && mem_req_r.addr == base_r)
        else $error("command word not cleared with zero");
    AST_REFR_READ: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ4]
        (mem_req_r.req && st_r == pbt_pkg::ST_REFR)
        |-> !mem_req_r.we && idx_r >= pbt_pkg::OFF_G1_FIRST && idx_r <= pbt_pkg::OFF_G1_LAST)
        else $error("refresh outside group one");
    AST_G2_ONCE: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ6]
        $rose(st_r == pbt_pkg::ST_LOAD2) |-> $past(st_r) == pbt_pkg::ST_LOAD1)
        else $error("group two load not preceded by group one pass");
    AST_LAMP: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ7]
        (g1_err_r || g2_err_r) [*2] |-> settings_error_lamp)
        else $error("lamp dark despite range error");
    AST_G1_IMM: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ9]
        (first_bad && is_g1_rd && !start) |=> g1_err_r && g1_off_r == $past(idx_r))
        else $error("group one error not recorded at once");
    AST_ERRW: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ8]
        (mem_req_r.req && st_r == pbt_pkg::ST_ERRW)
        |-> mem_req_r.we && mem_req_r.addr == 15'(base_r + {8'h00, pbt_pkg::OFF_DISP}))
        else $error("error offset written to wrong word");
    AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ14]
        restart_go |=> st_r == pbt_pkg::ST_CMD && !mem_req_r.req)
        else $error("restart did not rerun the sequence");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (|(status_r & mask_r)) |=> irq)
        else $error("irq low with unmasked status");
endmodule

// File: pbt_pkg.sv
// package: constants, layout, states and carriers of the parameter block transfer
package pbt_pkg;

    // =====================================================================
    // parameter block layout (word offsets from the block's first word)
    // =====================================================================
    localparam int          BLK_WORDS    = 100;
    localparam logic [14:0] BASE_WORD    = 15'h4E20;  // 20000
    localparam logic [14:0] UNIT_STRIDE  = 15'h0064;  // 100 words per unit
    localparam logic [6:0]  OFF_CMD      = 7'h00;
    localparam logic [6:0]  OFF_G1_FIRST = 7'h01;
    localparam logic [6:0]  OFF_G1_LAST  = 7'h10;
    localparam logic [6:0]  OFF_G2_FIRST = 7'h11;
    localparam logic [6:0]  OFF_G2_LAST  = 7'h30;
    localparam logic [6:0]  OFF_DISP     = 7'h5A;

    // =====================================================================
    // command word values, limits and defaults
    // =====================================================================
    localparam logic [15:0] CMD_UPLOAD   = 16'h3039;  // 12345
    localparam logic [15:0] CMD_CLEARED  = 16'h0000;
    localparam logic [15:0] G1_LIMIT     = 16'h7FFF;
    localparam logic [15:0] G2_LIMIT     = 16'h00FF;
    localparam logic [15:0] G1_DEFAULT   = 16'h0000;
    localparam logic [15:0] G2_DEFAULT   = 16'h0001;

    // =====================================================================
    // apb register map and fields
    // =====================================================================
    localparam logic [11:0] ADR_CTRL     = 12'h000;
    localparam logic [11:0] ADR_STATUS   = 12'h004;
    localparam logic [11:0] ADR_MASK     = 12'h008;
    localparam logic [11:0] ADR_STATE    = 12'h00C;
    localparam logic [11:0] ADR_CFG_SEL  = 12'h010;
    localparam logic [11:0] ADR_CFG_DATA = 12'h014;
    localparam int          EV_W         = 4;
    localparam int          EV_UPLOAD    = 0;
    localparam int          EV_LOADED    = 1;
    localparam int          EV_RANGE     = 2;
    localparam int          EV_RESTART   = 3;
    localparam logic [3:0]  MASK_RST     = 4'h0;
    localparam logic [3:0]  STATUS_RST   = 4'h0;
    localparam int          CTRL_RESTART = 0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_CMD   = 3'h1,
        ST_LOAD1 = 3'h3,
        ST_LOAD2 = 3'h2,
        ST_REFR  = 3'h6,
        ST_ERRW  = 3'h7,
        ST_UPLD  = 3'h5,
        ST_CLR   = 3'h4
    } pbt_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } pbt_mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } pbt_mem_rsp_t;

endpackage

// File: pbt_range_chk.sv
// range checker and default value source for one parameter word
`timescale 1ns/1ps
module pbt_range_chk (
    input  wire logic [6:0]  offset,
    input  wire logic [15:0] value,
    output logic             in_range,
    output logic [15:0]      def_value
);
    // =====================================================================
    // group selection by offset
    // =====================================================================
    wire in_g1 = (offset >= pbt_pkg::OFF_G1_FIRST) && (offset <= pbt_pkg::OFF_G1_LAST);

    assign in_range  = in_g1 ? (value <= pbt_pkg::G1_LIMIT) : (value <= pbt_pkg::G2_LIMIT);
    assign def_value = in_g1 ? pbt_pkg::G1_DEFAULT : pbt_pkg::G2_DEFAULT;
endmodule

// File: pbt_host_mem.sv
// host parameter memory model answering the unit's word requests
`timescale 1ns/1ps
module pbt_host_mem (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [6:0]            unit,
    input  wire logic [3:0]            delay,
    input  wire pbt_pkg::pbt_mem_req_t mem_req,
    output pbt_pkg::pbt_mem_rsp_t      mem_rsp,
    output logic                       bad_addr
);
    logic [15:0] mem [0:99];
    logic [15:0] last_r;
    logic [3:0]  wait_r;
    int          off;

    // block of 100 words at 20000 plus 100 per unit
    assign off = int'(mem_req.addr) - 20000 - 100 * int'(unit);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rsp <= '0;
            wait_r <= 4'h0;
            last_r <= 16'h0;
            bad_addr <= 1'b0;
        end else begin
            mem_rsp.ack <= 1'b0;
            // data lines carry no stale word outside an answer
            mem_rsp.rdata <= ~last_r;
            if (mem_req.req && !mem_rsp.ack) begin
                if (wait_r < delay) begin
                    wait_r <= wait_r + 4'h1;
                end else begin
                    wait_r <= 4'h0;
                    mem_rsp.ack <= 1'b1;
                    if (off < 0 || off > 99) begin
                        bad_addr <= 1'b1;
                    end else if (mem_req.we) begin
                        mem[off] <= mem_req.wdata;
                    end else begin
                        mem_rsp.rdata <= mem[off];
                        last_r <= mem[off];
                    end
                end
            end
        end
    end
endmodule

// File: pbt_param_xfer_test.sv
// testbench of the parameter block transfer against a host memory model
`timescale 1ns/1ps
module pbt_param_xfer_test;
    logic                  pclk, presetn, psel, penable, pwrite, restart_bit;
    logic                  pready, pslverr, lamp, irq, bad_addr, se;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd, acc;
    logic [3:0]            delay;
    pbt_pkg::pbt_mem_req_t mem_req;
    pbt_pkg::pbt_mem_rsp_t mem_rsp;
    int                    err_count, comparisons, cycles;

    pbt_param_xfer pbt_param_xfer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_sw(7'h03),
        .restart_bit(restart_bit), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .settings_error_lamp(lamp), .irq(irq));
    pbt_host_mem pbt_host_mem_inst (.pclk(pclk), .presetn(presetn), .unit(7'h03),
        .delay(delay), .mem_req(mem_req), .mem_rsp(mem_rsp), .bad_addr(bad_addr));

    // =====================================================================
    // clock, timeout and report
    // =====================================================================
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // =====================================================================
    // access tasks
    // =====================================================================
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // negative offset waits on the lamp, otherwise on a host word
    task automatic wt(input int off, input logic [15:0] e);
        for (int n = 0; n < 800; n++) begin
            @(posedge pclk);
            if (off < 0 ? lamp === e[0] : pbt_host_mem_inst.mem[off] === e)
                break;
        end
        chk(off < 0 ? "lamp" : "host word", {16'h0, e},
            off < 0 ? {31'h0, lamp} : {16'h0, pbt_host_mem_inst.mem[off]});
    endtask

    task automatic cfg(input logic [6:0] s, input logic [15:0] e);
        apb(1'b1, pbt_pkg::ADR_CFG_SEL, {25'h0, s});
        for (int n = 0; n < 30; n++) begin
            apb(1'b0, pbt_pkg::ADR_CFG_DATA, 32'h0);
            if (rd[15:0] === e)
                break;
        end
        chk("local word", {16'h0, e}, rd);
    endtask

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        restart_bit = 1'b0;
        delay = 4'h3;
        for (int i = 0; i < 100; i++)
            pbt_host_mem_inst.mem[i] = 16'hA5A5;
        pbt_host_mem_inst.mem[0] = pbt_pkg::CMD_UPLOAD;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, pbt_pkg::ADR_MASK, 32'h1);
        wt(0, pbt_pkg::CMD_CLEARED);
        chk("g1 default", {16'h0, pbt_pkg::G1_DEFAULT}, {16'h0, pbt_host_mem_inst.mem[16]});
        chk("g2 default", {16'h0, pbt_pkg::G2_DEFAULT}, {16'h0, pbt_host_mem_inst.mem[48]});
        repeat (4) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b0, pbt_pkg::ADR_STATUS, 32'h0);
        chk("status", 32'h1, rd & 32'h3);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        pbt_host_mem_inst.mem[2] = 16'h1234;
        pbt_host_mem_inst.mem[20] = 16'h0055;
        delay <= 4'h0;
        restart_bit <= 1'b1;
        repeat (4) @(posedge pclk);
        restart_bit <= 1'b0;
        acc = 32'h0;
        for (int n = 0; n < 200 && !acc[1]; n++) begin
            apb(1'b0, pbt_pkg::ADR_STATUS, 32'h0);
            acc = acc | rd;
        end
        chk("status", 32'hA, acc & 32'hF);
        cfg(7'h02, 16'h1234);
        cfg(7'h14, 16'h0055);
        pbt_host_mem_inst.mem[2] = 16'h4321;
        pbt_host_mem_inst.mem[20] = 16'h0066;
        cfg(7'h02, 16'h4321);
        cfg(7'h14, 16'h0055);
        pbt_host_mem_inst.mem[5] = 16'h8000;
        wt(-1, 16'h0001);
        wt(90, 16'h0005);
        pbt_host_mem_inst.mem[5] = 16'h0000;
        wt(-1, 16'h0000);
        pbt_host_mem_inst.mem[30] = 16'h0100;
        repeat (200) @(posedge pclk);
        chk("lamp", 32'h0, {31'h0, lamp});
        apb(1'b1, pbt_pkg::ADR_CTRL, 32'h1);
        wt(-1, 16'h0001);
        wt(90, 16'h001E);
        apb(1'b0, pbt_pkg::ADR_STATE, 32'h0);
        chk("state", {2'h0, 7'h03, 3'h6, 4'h5, 16'h001E}, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, se});
        chk("bad addr", 32'h0, {31'h0, bad_addr});
        wrap_up();
    end
endmodule
